//--- cfr_host_model.sv
// host side serial master that issues command frames, clock mode 0
`timescale 1ns/10ps
module cfr_host_model (
    output logic sclk_out, // serial clock, low between frames
    output logic cs_n_out, // frame select, active low
    output logic mosi_out, // command bits
    input wire logic miso_in // answer bits
);
    localparam realtime HALF = 62.5;
    // idle bus at time zero
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    task automatic xfer(input logic [31:0] cmd, input int nbits,
        output logic [31:0] rsp);
        rsp = 32'h0;
        cs_n_out = 1'b0;
        for (int i = 31; i >= 32 - nbits; i--) begin
            mosi_out = cmd[i]; // driven on the falling side
            #HALF sclk_out = 1'b1;
            rsp = {rsp[30:0], miso_in}; // sampled on the rising edge
            #HALF sclk_out = 1'b0;
        end
        #HALF cs_n_out = 1'b1;
        mosi_out = ~mosi_out; // released line shows no stale bit
        #300;
    endtask : xfer
endmodule : cfr_host_model

//--- cfr_pkg.sv
// package of constants and types for the current feedback readout block
package cfr_pkg;
    localparam int FRAME_W = 32;
    localparam int DIR_BIT = 31;
    localparam int CODE_HI = 30;
    localparam int CODE_LO = 27;
    localparam int CHANNEL_SELECT_HI = 26;
    localparam int CHANNEL_SELECT_LO = 24;
    localparam int PEAK_VALID_BIT = 22;
    localparam int AVG_VALID_BIT = 20;
    localparam int GON_DONE_BIT = 17;
    localparam int GOFF_DONE_BIT = 16;
    localparam logic [3:0] CODE_PEAK = 4'h5;
    localparam logic [3:0] CODE_AVG = 4'h6;
    localparam logic [3:0] CODE_CAL = 4'h7;
    localparam logic [10:0] MIN_RESET = 11'h7ff;
    localparam logic [10:0] MAX_RESET = 11'h000;
    localparam logic [19:0] AVG_RESET = 20'h00000;
    localparam int SUM_W = 20;
    localparam int SAMPLE_W = 12;
    // length of each of the two autozero phases (on, then off) in clock cycles
    localparam int CAL_CYCLES = 64;
    typedef enum logic [1:0] {CFR_CAL_IDLE, CFR_CAL_ON, CFR_CAL_OFF} cfr_cal_t;
endpackage : cfr_pkg

//--- cfr_readout.sv
// current feedback readout top: serial frames, peak, average and autozero
`timescale 1ns/10ps
module cfr_readout import cfr_pkg::*; #(
    parameter int CHANNELS = 8
) (
    input wire logic mclk_in, // 100 MHz clock
    input wire logic rst_n_in, // async reset, active low
    input wire logic sclk_in, // serial clock from host
    input wire logic cs_n_in, // frame select, active low
    input wire logic mosi_in, // serial data from host
    output logic miso_out, // serial data to host
    output logic miso_oe_out, // miso driven while selected
    input wire logic pwm_tick_in, // one pulse per pwm period
    input wire logic sample_vld_in, // new a/d sample
    input wire logic [SAMPLE_W-1:0] sample_in, // selected channel sample
    input wire logic [4:0] dither_steps_in, // steps per quarter
    input wire logic dither_zero_in, // step size is zero
    input wire logic [7:0] gon_offset_in, // measured gate-on offset
    input wire logic [7:0] goff_offset_in, // measured gate-off offset
    output logic [2:0] channel_select_out, // shared measured channel
    output logic cal_start_out, // pulse: start autozero
    output logic [2:0] cal_channel_select_out // autozero channel
);
    initial begin
        if (CHANNELS != 8) begin
            $error("cfr_readout: channel field is three bits, needs 8");
        end
    end

    // ==========================================================
    // reset release and pin synchronisation
    logic rst_s1, rst_n;
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // select goes through inverted so the reset value is the idle level
    logic [2:0] pins_s;
    cfr_sync #(.W(3)) u_sync (
        .mclk_in(mclk_in),
        .rst_n_in(rst_n),
        .d_in({sclk_in, ~cs_n_in, mosi_in}),
        .q_out(pins_s)
    );
    logic sclk_s, cs_n_s, mosi_s;
    assign sclk_s = pins_s[2];
    assign cs_n_s = ~pins_s[1];
    assign mosi_s = pins_s[0];

    // ==========================================================
    // serial shifter: sample on rise, shift out on fall
    logic sclk_d, cs_d;
    logic [5:0] bitcnt, next_bitcnt;
    logic [FRAME_W-1:0] rx, next_rx, tx, next_tx;
    logic frame_done, next_frame_done;
    logic [FRAME_W-1:0] resp;
    logic sclk_rise, sclk_fall, cs_fall;
    assign sclk_rise = sclk_s & ~sclk_d;
    assign sclk_fall = ~sclk_s & sclk_d;
    assign cs_fall = ~cs_n_s & cs_d;

    // frame capture and answer shifting
    always_comb begin
        next_bitcnt = bitcnt;
        next_rx = rx;
        next_tx = tx;
        next_frame_done = 1'b0;
        if (cs_fall) begin
            next_tx = resp;
            next_bitcnt = '0;
        end else if (!cs_n_s) begin
            if (sclk_rise) begin
                next_rx = {rx[FRAME_W-2:0], mosi_s};
                next_bitcnt = bitcnt + 6'h01;
            end else if (sclk_fall) begin
                next_tx = {tx[FRAME_W-2:0], 1'b0};
            end
        end else if (!cs_d && bitcnt == 6'h20) begin
            // one command per frame: count cleared so it acts once
            next_frame_done = 1'b1;
            next_bitcnt = '0;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d <= 1'b0;
            cs_d <= 1'b1;
            bitcnt <= '0;
            rx <= '0;
            tx <= '0;
            frame_done <= 1'b0;
            miso_out <= 1'b0;
            miso_oe_out <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
            cs_d <= cs_n_s;
            bitcnt <= next_bitcnt;
            rx <= next_rx;
            tx <= next_tx;
            frame_done <= next_frame_done;
            miso_out <= next_tx[FRAME_W-1];
            miso_oe_out <= ~cs_n_s;
        end
    end

    logic is_wr;
    logic [3:0] code;
    logic [2:0] fchan;
    assign is_wr = rx[DIR_BIT];
    assign code = rx[CODE_HI:CODE_LO];
    assign fchan = rx[CHANNEL_SELECT_HI:CHANNEL_SELECT_LO];
    logic peak_cmd, avg_cmd, cal_cmd;
    assign peak_cmd = frame_done && code == CODE_PEAK;
    assign avg_cmd = frame_done && code == CODE_AVG;
    assign cal_cmd = frame_done && code == CODE_CAL;

    // ==========================================================
    // dither period and accumulation
    logic [6:0] pwm_cnt, next_pwm_cnt;
    logic [SUM_W-1:0] per_sum, next_per_sum;
    logic [SUM_W-1:0] dsum, next_dsum;
    logic [10:0] run_max, next_run_max, run_min, next_run_min;
    logic [10:0] max_r, next_max_r, min_r, next_min_r;
    logic [SUM_W-1:0] avg_r, next_avg_r;
    logic peak_vld, next_peak_vld, avg_vld, next_avg_vld;
    logic discard, next_discard;
    logic [2:0] channel_select, next_channel_select;
    logic [6:0] period_len;
    logic [10:0] per_top;
    logic channel_select_chg;

    // four steps per dither step count
    // no dither: one pwm period per cycle
    always_comb begin
        if (dither_zero_in || dither_steps_in == 5'h00) begin
            period_len = 7'h01;
        end else begin
            period_len = {dither_steps_in, 2'b00};
        end
    end
    assign per_top = per_sum[SUM_W-1:SUM_W-11];
    assign channel_select_chg = (peak_cmd || avg_cmd) && fchan != channel_select;

    // accumulator and result next values
    always_comb begin
        next_pwm_cnt = pwm_cnt;
        next_per_sum = per_sum;
        next_dsum = dsum;
        next_run_max = run_max;
        next_run_min = run_min;
        next_max_r = max_r;
        next_min_r = min_r;
        next_avg_r = avg_r;
        next_peak_vld = peak_vld;
        next_avg_vld = avg_vld;
        next_discard = discard;
        next_channel_select = channel_select;
        if (sample_vld_in) begin
            next_per_sum = per_sum + SUM_W'(sample_in);
            next_dsum = dsum + SUM_W'(sample_in);
        end
        if (pwm_tick_in) begin
            next_per_sum = '0;
            next_run_max = (per_top > run_max) ? per_top : run_max;
            next_run_min = (per_top < run_min) ? per_top : run_min;
            if (pwm_cnt + 7'h01 >= period_len) begin
                next_pwm_cnt = '0;
                next_run_max = MAX_RESET;
                next_run_min = MIN_RESET;
                next_dsum = '0;
                next_discard = 1'b0;
                if (!discard) begin
                    next_max_r = (per_top > run_max) ? per_top : run_max;
                    next_min_r = (per_top < run_min) ? per_top : run_min;
                    next_avg_r = dsum;
                    next_peak_vld = 1'b1;
                    next_avg_vld = 1'b1;
                end
            end else begin
                next_pwm_cnt = pwm_cnt + 7'h01;
            end
        end
        if (peak_cmd) begin
            next_peak_vld = 1'b0;
        end
        if (avg_cmd) begin
            next_avg_vld = 1'b0;
        end
        if (channel_select_chg) begin
            next_channel_select = fchan;
            next_peak_vld = 1'b0;
            next_avg_vld = 1'b0;
            next_discard = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            pwm_cnt <= '0;
            per_sum <= '0;
            dsum <= '0;
            run_max <= MAX_RESET;
            run_min <= MIN_RESET;
            max_r <= MAX_RESET;
            min_r <= MIN_RESET;
            avg_r <= AVG_RESET;
            peak_vld <= 1'b0;
            avg_vld <= 1'b0;
            discard <= 1'b0;
            channel_select <= '0;
        end else begin
            pwm_cnt <= next_pwm_cnt;
            per_sum <= next_per_sum;
            dsum <= next_dsum;
            run_max <= next_run_max;
            run_min <= next_run_min;
            max_r <= next_max_r;
            min_r <= next_min_r;
            avg_r <= next_avg_r;
            peak_vld <= next_peak_vld;
            avg_vld <= next_avg_vld;
            discard <= next_discard;
            channel_select <= next_channel_select;
        end
    end

    // ==========================================================
    // autozero sequencer
    cfr_cal_t cal_st, next_cal_st;
    logic [6:0] cal_cnt, next_cal_cnt;
    logic gon_done, next_gon_done, goff_done, next_goff_done;
    logic [2:0] cal_ch, next_cal_ch;
    logic next_cal_start;
    localparam logic [6:0] CAL_LAST = 7'(CAL_CYCLES - 1);

    always_comb begin
        next_cal_st = cal_st;
        next_cal_cnt = cal_cnt;
        next_gon_done = gon_done;
        next_goff_done = goff_done;
        next_cal_ch = cal_ch;
        next_cal_start = 1'b0;
        case (cal_st)
            CFR_CAL_IDLE: begin
            end
            CFR_CAL_ON: begin
                next_cal_cnt = cal_cnt + 7'h01;
                if (cal_cnt == CAL_LAST) begin
                    next_cal_cnt = '0;
                    next_cal_st = CFR_CAL_OFF;
                end
            end
            CFR_CAL_OFF: begin
                next_cal_cnt = cal_cnt + 7'h01;
                if (cal_cnt == CAL_LAST) begin
                    next_gon_done = 1'b1;
                    next_goff_done = 1'b1;
                    next_cal_st = CFR_CAL_IDLE;
                end
            end
            default: begin
                next_cal_st = CFR_CAL_IDLE;
            end
        endcase
        if (cal_cmd) begin
            next_gon_done = 1'b0;
            next_goff_done = 1'b0;
            if (is_wr) begin
                next_cal_st = CFR_CAL_ON;
                next_cal_cnt = '0;
                next_cal_ch = fchan;
                next_cal_start = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            cal_st <= CFR_CAL_IDLE;
            cal_cnt <= '0;
            gon_done <= 1'b0;
            goff_done <= 1'b0;
            cal_ch <= '0;
            cal_start_out <= 1'b0;
        end else begin
            cal_st <= next_cal_st;
            cal_cnt <= next_cal_cnt;
            gon_done <= next_gon_done;
            goff_done <= next_goff_done;
            cal_ch <= next_cal_ch;
            cal_start_out <= next_cal_start;
        end
    end
    assign channel_select_out = channel_select;
    assign cal_channel_select_out = cal_ch;

    // ==========================================================
    // answer built from the previous frame, zeros elsewhere
    // unused bits zero
    always_comb begin
        resp = '0;
        resp[CODE_HI:CODE_LO] = code;
        resp[CHANNEL_SELECT_HI:CHANNEL_SELECT_LO] = fchan;
        case (code)
            CODE_PEAK: begin
                resp[PEAK_VALID_BIT] = peak_vld;
                resp[21:11] = max_r;
                resp[10:0] = min_r;
            end
            CODE_AVG: begin
                resp[AVG_VALID_BIT] = avg_vld;
                resp[19:0] = avg_r;
            end
            CODE_CAL: begin
                resp[GON_DONE_BIT] = gon_done;
                resp[GOFF_DONE_BIT] = goff_done;
                resp[15:8] = gon_offset_in;
                resp[7:0] = goff_offset_in;
            end
            default: begin
                resp = '0;
            end
        endcase
    end
endmodule : cfr_readout

//--- cfr_readout_props.sv
// checker of serial framing and autozero start timing at the top ports
`timescale 1ns/10ps
module cfr_readout_props (
    input wire logic mclk_in, // system clock
    input wire logic rst_n_in, // reset, active low
    input wire logic sclk_in, // host serial clock
    input wire logic cs_n_in, // frame select, active low
    input wire logic miso_out, // answer bit
    input wire logic miso_oe_out, // answer enable
    input wire logic [2:0] channel_select_out, // shared channel
    input wire logic cal_start_out, // autozero start pulse
    input wire logic [2:0] cal_channel_select_out // autozero channel
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    // ==================================================================
    // autozero start
    // one start per frame, only once the frame has ended
    cal_gap_a: assert property (cal_start_out |=> !cal_start_out [*8])
        else $error("autozero start repeated");
    cal_in_gap_a: assert property (cal_start_out |-> cs_n_in && $past(cs_n_in, 2))
        else $error("autozero start inside a frame");
    cal_channel_select_tie_a: assert property ($changed(cal_channel_select_out) |-> cal_start_out || $past(cal_start_out))
        else $error("autozero channel moved without a start");
    // ==================================================================
    // framing and answer line
    // enable follows the frame select within the synchroniser delay
    oe_rise_a: assert property ($fell(cs_n_in) |-> ##[1:5] miso_oe_out)
        else $error("answer not enabled after frame start");
    oe_drop_a: assert property ($rose(cs_n_in) |-> ##[1:5] !miso_oe_out)
        else $error("answer still enabled after frame end");
    channel_select_hold_a: assert property ($changed(channel_select_out) |-> cs_n_in && $past(cs_n_in))
        else $error("channel changed inside a frame");
    miso_steady_a: assert property ($rose(sclk_in) && !cs_n_in |-> $stable(miso_out))
        else $error("answer bit moved at a sampling edge");
    miso_shift_a: assert property ($changed(miso_out) && !cs_n_in |-> !sclk_in)
        else $error("answer bit moved while serial clock high");
endmodule : cfr_readout_props

//--- cfr_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module cfr_sync #(
    parameter int W = 1
) (
    input wire logic mclk_in, // system clock
    input wire logic rst_n_in, // active low reset
    input wire logic [W-1:0] d_in, // asynchronous input
    output logic [W-1:0] q_out // synchronised output
);
    logic [W-1:0] stage1;
    // first stage feeds only the second
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stage1 <= '0;
            q_out <= '0;
        end else begin
            stage1 <= d_in;
            q_out <= stage1;
        end
    end
endmodule : cfr_sync

//--- test_current_feedback_readout.sv
// self-checking bench for the current feedback readout block
`timescale 1ns/10ps
module test_current_feedback_readout;
    typedef struct {logic [31:0] cmd; int cyc; logic [31:0] exp;} cfr_row_t;
    localparam int STEPS = 2;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic pwm_tick = 1'b0;
    logic sample_vld = 1'b0;
    logic [cfr_pkg::SAMPLE_W-1:0] sample = 12'h000;
    logic dither_zero = 1'b0;
    logic sclk, cs_n, mosi, miso, miso_oe, cal_start;
    logic [2:0] channel_select, cal_channel_select;
    logic [31:0] rsp;
    int miscompares = 0;
    int num_checks = 0;
    // each row: dither cycles run first, then the frame and its answer
    cfr_row_t rows [10] = '{
        '{32'h2a000000, 0, 32'h00000000},
        '{32'h32000000, 2, 32'h2a40f804},
        '{32'h2a000000, 1, 32'h321107fc},
        '{32'h2b000000, 0, 32'h2a00f804},
        '{32'h33000000, 2, 32'h2b40f804},
        '{32'h00000000, 0, 32'h330107fc},
        '{32'h38000000, 0, 32'h00000000},
        '{32'hbd000000, 0, 32'h38005ac3},
        '{32'h3d000000, 3, 32'h3d035ac3},
        '{32'h00000000, 0, 32'h3d005ac3}
    };
    // ==================================================================
    // clock, design and host
    initial begin
        forever #5 mclk = ~mclk;
    end
    cfr_readout uut (
        .mclk_in(mclk), .rst_n_in(rst_n), .sclk_in(sclk), .cs_n_in(cs_n),
        .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe),
        .pwm_tick_in(pwm_tick), .sample_vld_in(sample_vld),
        .sample_in(sample), .dither_steps_in(5'(STEPS)),
        .dither_zero_in(dither_zero), .gon_offset_in(8'h5a),
        .goff_offset_in(8'hc3), .channel_select_out(channel_select),
        .cal_start_out(cal_start), .cal_channel_select_out(cal_channel_select)
    );
    cfr_host_model host (
        .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso)
    );
    // ==================================================================
    // tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : conclude
    task automatic do_reset();
        rst_n = 1'b0;
        repeat (10) @(posedge mclk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge mclk);
    endtask : do_reset
    task automatic frame(input logic [31:0] cmd, input int n);
        @(posedge mclk);
        #1 host.xfer(cmd, n, rsp);
    endtask : frame
    // pwm periods of four equal samples; period 3 largest, period 5 smallest
    // sample sums kept far below the 20-bit overflow limit
    task automatic run_cycles(input int n);
        int per;
        per = dither_zero ? 1 : 4 * STEPS;
        for (int i = 0; i < n * per; i++) begin
            sample = (i % 8 == 3) ? 12'hfff : (i % 8 == 5) ? 12'h200 : 12'h800;
            repeat (4) @(posedge mclk) #1 sample_vld = 1'b1;
            @(posedge mclk) #1 sample_vld = 1'b0;
            pwm_tick = 1'b1;
            @(posedge mclk) #1 pwm_tick = 1'b0;
        end
    endtask : run_cycles
    // ==================================================================
    // main sequence: table, then reset and awkward cases
    initial begin
        do_reset();
        foreach (rows[i]) begin
            run_cycles(rows[i].cyc);
            frame(rows[i].cmd, 32);
            check(rsp, rows[i].exp);
        end
        check({29'h0, channel_select}, 32'h3);
        check({29'h0, cal_channel_select}, 32'h5);
        // second reset in mid-run, dither switched off
        dither_zero = 1'b1;
        do_reset();
        check({28'h0, miso_oe, channel_select}, 32'h0);
        frame(32'h28000000, 32);
        frame(32'h30000000, 32);
        check(rsp, 32'h280007ff);
        frame(32'h30000000, 32);
        check(rsp, 32'h30000000);
        run_cycles(2);
        frame(32'h00000000, 32);
        check(rsp, 32'h30102000);
        // a frame cut short is ignored
        frame(32'h2e000000, 16);
        check({29'h0, channel_select}, 32'h0);
        frame(32'h00000000, 32);
        check(rsp, 32'h00000000);
        conclude();
    end
    // watchdog well beyond the expected run of under 100 us
    initial begin
        #400us;
        miscompares++;
        conclude();
    end
endmodule : test_current_feedback_readout
bind cfr_readout cfr_readout_props u_props (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .sclk_in(sclk_in),
    .cs_n_in(cs_n_in), .miso_out(miso_out), .miso_oe_out(miso_oe_out),
    .channel_select_out(channel_select_out), .cal_start_out(cal_start_out),
    .cal_channel_select_out(cal_channel_select_out)
);
